// >>> common/spsp_pkg.sv
// package for the serial slave port: register map, field layout, reset values
// assumes a 32-bit axi4-lite register bus, byte addresses, one word per register
package spsp_pkg;
	localparam logic [3:0] ADDR_CFG    = 4'h0;
	localparam logic [3:0] ADDR_TXBUF  = 4'h4;
	localparam logic [3:0] ADDR_RXBUF  = 4'h8;
	localparam logic [3:0] ADDR_CTRL   = 4'hC;
	localparam int         ADDR_W      = 4;
	// configuration fields
	localparam int CFG_CLKSEL_LO = 5;
	localparam int CFG_BYPASS    = 4;
	localparam int CFG_SSVAL     = 3;
	localparam int CFG_SSEN_N    = 2;
	localparam int CFG_IRQSRC    = 1;
	localparam int CFG_SLAVE     = 0;
	// control and flag fields
	localparam int CTL_LSBF   = 7;
	localparam int CTL_OVR    = 6;
	localparam int CTL_DONE   = 5;
	localparam int CTL_TXE    = 4;
	localparam int CTL_RXF    = 3;
	localparam int CTL_CPHA   = 2;
	localparam int CTL_CPOL   = 1;
	localparam int CTL_EN     = 0;
	localparam logic [7:0] CFG_RESET  = 8'h05;
	localparam logic [7:0] CTL_RESET  = 8'h00;
	localparam logic [7:0] CTL_FLAGS  = 8'h78;
	localparam logic [2:0] BIT_LAST   = 3'h7;
	localparam logic [1:0] RESP_OKAY  = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [1:0] {
		SPSP_IDLE  = 2'b00,
		SPSP_SHIFT = 2'b01,
		SPSP_DONE  = 2'b10
	} spsp_state_t;
endpackage : spsp_pkg

// >>> rtl/spsp_top.sv
// serial slave port: 8-bit full duplex shifter with axi4-lite register access
// assumes the master's sclk is far slower than aclk; pins are asynchronous
// Overview of operation
// R01: clock select code picks aclk divided by 2..256 as sampling tick rate.
// R02: bypass bit skips the two-stage synchroniser on serial inputs.
// R03: with select enable low, slave select follows the config value bit.
// R04: select enable high takes slave select from the external pin.
// R05: interrupt source bit picks holding-empty or transfer-complete event.
// R06: role bit exists; this block always acts as slave.
// R07: byte in transmit buffer loads into shifter while enabled.
// R08: completed shifter byte is copied into receive buffer.
// R09: control bit 7 set shifts least significant bit first.
// R10: bit 6 flags a byte received before previous one was read.
// R11: bit 5 flags a finished eight-bit transfer.
// R12: bit 4 reports empty transmit buffer.
// R13: bit 3 flags receive buffer full.
// R14: control bits 2 and 1 give phase and polarity; master must match.
// R15: block works only while enable bit 0 is set, otherwise idle.
// R16: reading control register clears the flags that read reported.
// R17: holding-empty fires on load to shifter; complete after last bit.
// R18: eight bits full duplex per transfer while select is low.
// R19: output driven only while selected; clocks ignored when deselected.
//
// Design decisions made here: the address map and register access over AXI4-Lite.
module spsp_top
	import spsp_pkg::*;
(
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	input  wire logic              sclk,
	input  wire logic              mosi,
	input  wire logic              ss_n,
	output logic                   miso,
	output logic                   miso_oe,
	output logic                   irq
);
	logic [7:0]  cfg_reg;
	logic [7:0]  ctl_reg;
	logic [7:0]  txbuf_reg;
	logic [7:0]  rxbuf_reg;
	logic [7:0]  shift_reg;
	logic [2:0]  bitcnt_reg;
	logic [7:0]  div_reg;
	logic [2:0]  sync1_reg;
	logic [2:0]  sync2_reg;
	logic [2:0]  samp_reg;
	logic        sclk_prev_reg;
	logic        txfull_reg;
	logic        loaded_reg;
	logic        evt_hold;
	logic        evt_last;
	spsp_state_t state_reg;

	// axi write path
	logic              aw_have_reg;
	logic              w_have_reg;
	logic [ADDR_W-1:0] awaddr_reg;
	logic [31:0]       wdata_reg;
	logic [3:0]        wstrb_reg;
	logic              wr_fire;
	logic              rd_fire;
	logic              rd_ctl;
	logic              wr_tx;

	function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
		addr_mapped = (a == ADDR_CFG) || (a == ADDR_TXBUF) ||
		              (a == ADDR_RXBUF) || (a == ADDR_CTRL);
	endfunction : addr_mapped

	assign wr_fire = aw_have_reg && w_have_reg && !s_axi_bvalid;
	assign wr_tx   = wr_fire && (awaddr_reg == ADDR_TXBUF) && wstrb_reg[0];
	assign rd_fire = s_axi_arvalid && s_axi_arready;
	assign rd_ctl  = rd_fire && (s_axi_araddr == ADDR_CTRL);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_reg   <= 1'b0;
			w_have_reg    <= 1'b0;
			awaddr_reg    <= '0;
			wdata_reg     <= '0;
			wstrb_reg     <= '0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= RESP_OKAY;
		end else begin
			s_axi_awready <= !aw_have_reg && !s_axi_awready && !s_axi_bvalid;
			s_axi_wready  <= !w_have_reg && !s_axi_wready && !s_axi_bvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_reg   <= 1'b1;
				awaddr_reg    <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have_reg   <= 1'b1;
				wdata_reg    <= s_axi_wdata;
				wstrb_reg    <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (wr_fire) begin
				aw_have_reg  <= 1'b0;
				w_have_reg   <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= addr_mapped(awaddr_reg) ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// axi read path; single-cycle arready pulse, data one edge later
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= '0;
			s_axi_rresp   <= RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
			if (rd_fire) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= addr_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
				if (s_axi_araddr == ADDR_CFG)
					s_axi_rdata <= {24'h000000, cfg_reg};
				else if (s_axi_araddr == ADDR_RXBUF)
					s_axi_rdata <= {24'h000000, rxbuf_reg};
				else if (s_axi_araddr == ADDR_CTRL)
					s_axi_rdata <= {24'h000000, ctl_reg};
				else
					s_axi_rdata <= '0;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// configuration; role bit kept but the shifter is always a slave
	always_ff @(posedge aclk) begin
		if (!aresetn)
			cfg_reg <= CFG_RESET;
		else if (wr_fire && awaddr_reg == ADDR_CFG && wstrb_reg[0])
			cfg_reg <= wdata_reg[7:0]; // R06
	end

	// clock divider gives the sampling tick
	logic [7:0] div_top;
	logic       tick;
	assign div_top = 8'((9'h002 << cfg_reg[7:CFG_CLKSEL_LO]) - 9'h001); // R01
	assign tick    = (div_reg >= div_top);
	always_ff @(posedge aclk) begin
		if (!aresetn)
			div_reg <= '0;
		else if (tick)
			div_reg <= '0;
		else
			div_reg <= div_reg + 8'h01;
	end

	// pin synchroniser; first stage read only by the second
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sync1_reg <= 3'h7;
			sync2_reg <= 3'h7;
		end else begin
			sync1_reg <= {sclk, mosi, ss_n};
			sync2_reg <= sync1_reg;
		end
	end

	logic [2:0] pins_in;
	assign pins_in = cfg_reg[CFG_BYPASS] ? {sclk, mosi, ss_n} : sync2_reg; // R02
	always_ff @(posedge aclk) begin
		if (!aresetn)
			samp_reg <= 3'h5;
		else if (tick)
			samp_reg <= pins_in;
	end

	logic sel_n;
	logic sck_n;
	logic edge_any;
	logic lead;
	logic sample_edge;
	logic shift_edge;
	assign sel_n = cfg_reg[CFG_SSEN_N] ? samp_reg[0] : cfg_reg[CFG_SSVAL]; // R03 R04
	assign sck_n = samp_reg[2] ^ ctl_reg[CTL_CPOL]; // R14
	assign edge_any = tick && (pins_in[2] ^ ctl_reg[CTL_CPOL]) != sck_n;
	assign lead = edge_any && !sck_n;
	assign sample_edge = edge_any && (ctl_reg[CTL_CPHA] ? sck_n : !sck_n); // R14
	assign shift_edge  = edge_any && (ctl_reg[CTL_CPHA] ? !sck_n : sck_n);

	logic active;
	logic last_in;
	logic [7:0] shin;
	assign active  = ctl_reg[CTL_EN] && !sel_n; // R15 R19
	assign last_in = active && sample_edge && bitcnt_reg == BIT_LAST;
	assign shin = ctl_reg[CTL_LSBF] ? {samp_reg[1], shift_reg[7:1]}
	                                : {shift_reg[6:0], samp_reg[1]}; // R09
	logic cur_out;
	assign cur_out = ctl_reg[CTL_LSBF] ? shift_reg[0] : shift_reg[7]; // R09

	// shifter state machine; deselect drops a cut frame so the next byte can load
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_reg  <= SPSP_IDLE;
			shift_reg  <= '0;
			bitcnt_reg <= '0;
			loaded_reg <= 1'b0;
		end else begin
			loaded_reg <= 1'b0;
			case (state_reg)
				SPSP_IDLE: begin
					bitcnt_reg <= '0;
					if (ctl_reg[CTL_EN] && txfull_reg) begin
						shift_reg  <= txbuf_reg; // R07
						loaded_reg <= 1'b1;
						state_reg  <= SPSP_SHIFT;
					end else if (active) begin
						state_reg <= SPSP_SHIFT;
					end
				end
				SPSP_SHIFT: begin
					if (!active) begin
						state_reg <= SPSP_IDLE; // R15 R19
					end else if (sample_edge && active) begin
						shift_reg  <= shin; // R18
						bitcnt_reg <= bitcnt_reg + 3'h1;
						if (bitcnt_reg == BIT_LAST)
							state_reg <= SPSP_DONE;
					end
				end
				SPSP_DONE: begin
					bitcnt_reg <= '0;
					state_reg  <= SPSP_IDLE;
				end
				default: state_reg <= SPSP_IDLE;
			endcase
		end
	end

	assign evt_hold = loaded_reg; // R17
	assign evt_last = state_reg == SPSP_DONE; // R17

	// output pin; cpha=0 presents the first bit as soon as selected
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			miso    <= 1'b0;
			miso_oe <= 1'b0;
		end else begin
			miso_oe <= active; // R19
			if (!active || (shift_edge && !lead) || (shift_edge && ctl_reg[CTL_CPHA]))
				miso <= cur_out;
			else if (state_reg != SPSP_SHIFT)
				miso <= cur_out;
		end
	end

	// buffers
	logic rx_unread_reg;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			txbuf_reg     <= '0;
			txfull_reg    <= 1'b0;
			rxbuf_reg     <= '0;
			rx_unread_reg <= 1'b0;
		end else begin
			if (wr_tx) begin
				txbuf_reg  <= wdata_reg[7:0];
				txfull_reg <= 1'b1;
			end else if (loaded_reg) begin
				txfull_reg <= 1'b0;
			end
			if (evt_last) begin
				rxbuf_reg     <= shift_reg; // R08
				rx_unread_reg <= 1'b1;
			end else if (rd_fire && s_axi_araddr == ADDR_RXBUF) begin
				rx_unread_reg <= 1'b0;
			end
		end
	end

	// control: software bits plus sticky flags; set beats the read-clear
	logic [7:0] rd_clr;
	assign rd_clr = rd_ctl ? (ctl_reg & CTL_FLAGS) : 8'h00; // R16
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctl_reg <= CTL_RESET;
		end else begin
			if (wr_fire && awaddr_reg == ADDR_CTRL && wstrb_reg[0]) begin
				ctl_reg[CTL_LSBF] <= wdata_reg[CTL_LSBF];
				ctl_reg[CTL_CPHA] <= wdata_reg[CTL_CPHA];
				ctl_reg[CTL_CPOL] <= wdata_reg[CTL_CPOL];
				ctl_reg[CTL_EN]   <= wdata_reg[CTL_EN];
			end
			ctl_reg[CTL_OVR]  <= (evt_last && rx_unread_reg) ||
			                     (ctl_reg[CTL_OVR] && !rd_clr[CTL_OVR]); // R10
			ctl_reg[CTL_DONE] <= evt_last || (ctl_reg[CTL_DONE] && !rd_clr[CTL_DONE]); // R11
			ctl_reg[CTL_TXE]  <= evt_hold || (ctl_reg[CTL_TXE] && !rd_clr[CTL_TXE]
			                     && !wr_tx); // R12
			ctl_reg[CTL_RXF]  <= evt_last || (ctl_reg[CTL_RXF] && !rd_clr[CTL_RXF]); // R13
		end
	end

	// interrupt level; held until the selected flag is cleared by a read, or for holding-empty by a transmit buffer write
	always_ff @(posedge aclk) begin
		if (!aresetn)
			irq <= 1'b0;
		else
			irq <= cfg_reg[CFG_IRQSRC] ? ctl_reg[CTL_DONE] : ctl_reg[CTL_TXE]; // R05
	end

	property p_done_after_last;
		@(posedge aclk) disable iff (!aresetn)
		last_in |=> ##1 ctl_reg[CTL_DONE];
	endproperty
	a_done_after_last: assert property (p_done_after_last)
		else $error("done flag missing after last bit"); // R11

	property p_rx_copy;
		@(posedge aclk) disable iff (!aresetn)
		evt_last |=> rxbuf_reg == $past(shift_reg);
	endproperty
	a_rx_copy: assert property (p_rx_copy)
		else $error("receive buffer not loaded"); // R08

	property p_overrun;
		@(posedge aclk) disable iff (!aresetn)
		evt_last && rx_unread_reg |=> ctl_reg[CTL_OVR];
	endproperty
	a_overrun: assert property (p_overrun)
		else $error("overrun not flagged"); // R10

	property p_rxf;
		@(posedge aclk) disable iff (!aresetn)
		evt_last |=> ctl_reg[CTL_RXF];
	endproperty
	a_rxf: assert property (p_rxf)
		else $error("receive full not flagged"); // R13

	property p_txe_load;
		@(posedge aclk) disable iff (!aresetn)
		state_reg == SPSP_IDLE && ctl_reg[CTL_EN] && txfull_reg |=> ##1 ctl_reg[CTL_TXE];
	endproperty
	a_txe_load: assert property (p_txe_load)
		else $error("tx empty not flagged on load"); // R12

	property p_idle_when_off;
		@(posedge aclk) disable iff (!aresetn)
		!ctl_reg[CTL_EN] |=> state_reg != SPSP_SHIFT;
	endproperty
	a_idle_when_off: assert property (p_idle_when_off)
		else $error("shifter runs while disabled"); // R15

	sequence s_back_to_idle;
		state_reg == SPSP_IDLE ##1 bitcnt_reg == 3'h0;
	endsequence
	property p_frame_cut;
		@(posedge aclk) disable iff (!aresetn)
		state_reg == SPSP_SHIFT && !active |=> s_back_to_idle;
	endproperty
	a_frame_cut: assert property (p_frame_cut)
		else $error("cut frame not abandoned"); // R19

	property p_oe_sel;
		@(posedge aclk) disable iff (!aresetn)
		sel_n |=> !miso_oe;
	endproperty
	a_oe_sel: assert property (p_oe_sel)
		else $error("output driven while deselected"); // R19

	property p_rd_clear;
		@(posedge aclk) disable iff (!aresetn)
		rd_ctl && !evt_last && !evt_hold |=> !ctl_reg[CTL_DONE] && !ctl_reg[CTL_RXF];
	endproperty
	a_rd_clear: assert property (p_rd_clear)
		else $error("flags not cleared by read"); // R16

	property p_irq_src;
		@(posedge aclk) disable iff (!aresetn)
		cfg_reg[CFG_IRQSRC] && ctl_reg[CTL_DONE] |=> irq;
	endproperty
	a_irq_src: assert property (p_irq_src)
		else $error("interrupt source not followed"); // R05
endmodule : spsp_top

// >>> test/spsp_master_model.sv
// spi master model driving the serial pins of the slave port
// assumes the bench's aclk; frames are paced in aclk cycles
module spsp_master_model (
	input  wire logic aclk,
	output logic      sclk,
	output logic      mosi,
	output logic      ss_n,
	input  wire logic miso,
	input  wire logic miso_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	// 24 cycles keeps at least 6 ticks per half period at clock select 0 or 1
	localparam int HALF = 24;
	initial begin
		sclk = 1'b0;
		mosi = 1'b0;
		ss_n = 1'b1;
	end
	task automatic half;
		repeat (HALF) @(posedge aclk);
	endtask : half
	// mode is {lsb first, phase, polarity}; sclk stands at idle outside frames
	task automatic xfer(input logic [7:0] tx, input logic [2:0] mode, output logic [7:0] rx);
		int i;
		int k;
		sclk <= mode[0];
		half();
		ss_n <= 1'b0;
		for (i = 0; i < 8; i++) begin
			k = mode[2] ? i : 7 - i;
			if (!mode[1]) mosi <= tx[k];
			half();
			sclk <= ~mode[0];
			if (mode[1]) mosi <= tx[k];
			else rx[k] = miso_oe ? miso : 1'bx;
			half();
			sclk <= mode[0];
			if (mode[1]) rx[k] = miso_oe ? miso : 1'bx;
		end
		half();
		ss_n <= 1'b1;
		// a released line shows the inverse so a stale level never passes
		mosi <= ~mosi;
	endtask : xfer
endmodule : spsp_master_model

// >>> test/spi_slave_port_tb_top.sv
// self-checking bench for the serial slave port
// assumes spsp_master_model on the pins and axi4-lite register access
module spi_slave_port_tb_top
	import spsp_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic        aclk = 1'b0, aresetn = 1'b0;
	logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'h0;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
	logic        sclk, mosi, ss_n, miso, miso_oe, irq;
	logic [7:0]  got, ctl;
	int          failures = 0, check_count = 0, oe_cnt = 0, o, i;
	// row: configuration, mode {lsb first, phase, polarity}, slave byte, master byte
	logic [31:0] rows [4] = '{32'h05_00_A5_3C, 32'h15_05_81_7E, 32'h25_06_96_E1, 32'h35_03_0F_F0};
	always #2 aclk = ~aclk;
	always @(posedge aclk) oe_cnt <= oe_cnt + ((miso_oe === 1'b1) ? 1 : 0);
	spsp_top spsp_top_inst (
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
		.sclk(sclk), .mosi(mosi), .ss_n(ss_n), .miso(miso), .miso_oe(miso_oe), .irq(irq)
	);
	spsp_master_model spsp_master_model_inst (
		.aclk(aclk), .sclk(sclk), .mosi(mosi), .ss_n(ss_n), .miso(miso), .miso_oe(miso_oe)
	);
	task automatic final_report;
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : final_report
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		check_count++;
		if (g !== e) begin
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
			failures++;
		end
	endtask : chk
	// one edge first so a strobe is never assigned twice in one time step
	task automatic axw(input logic [3:0] a, input logic [7:0] d);
		int n;
		@(posedge aclk);
		n = 0;
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, d};
		s_axi_wstrb <= 4'hF;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			n++;
			if (n > 100) begin
				failures++;
				final_report();
			end
		end while (!(s_axi_bvalid === 1'b1));
		rsp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask : axw
	task automatic axr(input logic [3:0] a);
		int n;
		@(posedge aclk);
		n = 0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			n++;
			if (n > 100) begin
				failures++;
				final_report();
			end
		end while (!(s_axi_rvalid === 1'b1));
		rd = s_axi_rdata;
		rsp = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : axr
	initial begin
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		axr(ADDR_CFG);
		chk(rd[7:0], CFG_RESET);
		axr(ADDR_CTRL);
		chk(rd[7:0], CTL_RESET);
		axr(4'h2);
		chk({6'h0, rsp}, {6'h0, RESP_SLVERR});
		chk(rd[7:0], 8'h00);
		axw(4'h2, 8'hFF);
		chk({6'h0, rsp}, {6'h0, RESP_SLVERR});
		axr(ADDR_CFG);
		chk(rd[7:0], CFG_RESET);
		for (i = 0; i < 4; i++) begin
			axw(ADDR_CFG, rows[i][31:24]);
			ctl = {rows[i][18], 4'h0, rows[i][17:16], 1'b1};
			axw(ADDR_CTRL, ctl);
			axw(ADDR_TXBUF, rows[i][15:8]);
			chk({6'h0, rsp}, {6'h0, RESP_OKAY});
			spsp_master_model_inst.xfer(rows[i][7:0], rows[i][18:16], got);
			chk(got, rows[i][15:8]);
			chk({7'h0, irq}, 8'h01);
			axr(ADDR_CTRL);
			chk(rd[7:0], ctl | 8'h38);
			axr(ADDR_CTRL);
			chk(rd[7:0], ctl);
			axr(ADDR_RXBUF);
			chk(rd[7:0], rows[i][7:0]);
		end
		// two bytes without reading the first one
		axw(ADDR_CFG, 8'h07);
		spsp_master_model_inst.xfer(8'h11, 3'h3, got);
		spsp_master_model_inst.xfer(8'h22, 3'h3, got);
		chk({7'h0, irq}, 8'h01);
		axr(ADDR_CTRL);
		chk(rd[7:0], 8'h07 | 8'h68);
		axr(ADDR_RXBUF);
		chk(rd[7:0], 8'h22);
		chk({7'h0, irq}, 8'h00);
		// internal select held high, then the block disabled
		for (i = 0; i < 2; i++) begin
			axw(ADDR_CFG, (i != 0) ? 8'h05 : 8'h09);
			axw(ADDR_CTRL, (i != 0) ? 8'h06 : 8'h07);
			o = oe_cnt;
			spsp_master_model_inst.xfer(8'h33, 3'h3, got);
			chk(8'(oe_cnt - o), 8'h00);
			axr(ADDR_CTRL);
			chk(rd[7:0], (i != 0) ? 8'h06 : 8'h07);
		end
		aresetn <= 1'b0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		axr(ADDR_CFG);
		chk(rd[7:0], CFG_RESET);
		chk({7'h0, irq}, 8'h00);
		final_report();
	end
endmodule : spi_slave_port_tb_top
